// ==== logic/pio_pkg.sv ====
package pio_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [3:0] IDX_WEST_DATA   = 4'h0;
   localparam logic [3:0] IDX_MIDDLE_DATA = 4'h1;
   localparam logic [3:0] IDX_EAST_DATA   = 4'h2;
   localparam logic [3:0] IDX_WEST_DIR    = 4'h4;
   localparam logic [3:0] IDX_MIDDLE_DIR  = 4'h5;
   localparam logic [3:0] IDX_EAST_DIR    = 4'h6;
   localparam logic [3:0] IDX_CONV_SEL    = 4'h8;
   localparam logic [3:0] IDX_TIMER_SEL   = 4'h9;
   localparam logic [3:0] IDX_PIN_STATUS  = 4'ha;
   localparam int         WEST_W          = 7;
   localparam int         MIDDLE_W        = 8;
   localparam int         EAST_W          = 5;
   localparam int         CHSEL_W         = 5;
   localparam int         TIMER_CH        = 2;
   localparam int         TIMER_BASE      = 6;
   localparam int         SYSCLK_PIN      = 2;
   localparam int         SYSCLK_EN_BIT   = 7;
   localparam logic [4:0] CHSEL_RST       = 5'h1f;
   localparam logic [7:0] DIR_RST         = 8'h00;
   localparam logic [1:0] TIMER_RST       = 2'h0;
endpackage

// ==== logic/pio_sync.sv ====
`timescale 1ns/10ps
module pio_sync #(
   parameter int W = 8
) (
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_sync;

   always_comb begin
      nxt_meta = async_in;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign sync_out = sync_ff;
endmodule

// ==== logic/pio_port.sv ====
`timescale 1ns/10ps
module pio_port #(
   parameter int W = 8
) (
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic         wr_latch,
   input  wire logic         wr_dir,
   input  wire logic [W-1:0] wdata,
   input  wire logic [W-1:0] pin_sync,
   output logic      [W-1:0] latch,
   output logic      [W-1:0] dir,
   output logic      [W-1:0] rd_val
);
   logic [W-1:0] latch_ff;
   logic [W-1:0] dir_ff;
   logic [W-1:0] nxt_latch;
   logic [W-1:0] nxt_dir;

   always_comb begin
      nxt_latch = wr_latch ? wdata : latch_ff;
      nxt_dir   = wr_dir ? wdata : dir_ff;
   end

   always_ff @(posedge core_clk) begin
      latch_ff <= nxt_latch;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dir_ff <= '0;
      end else begin
         dir_ff <= nxt_dir;
      end
   end

   assign latch  = latch_ff;
   assign dir    = dir_ff;
   assign rd_val = (dir_ff & latch_ff) | (~dir_ff & pin_sync);
endmodule

// ==== logic/pio_top.sv ====
// Notes on behaviour
// - West port: seven pins, latch and direction
// - Data latches are not reset
// - Direction one drives pin, zero floats
// - Reset clears west and middle directions
// - West read: output bits give latch
// - West read: input bits give pin
// - Data writes always update the latch
// - Middle port: eight pins, latch or pin
// - Converter wins over timer on pins
// - Converter pin reads zero or latch
// - Converter pin ignores direction for drive
// - Channel select picks analog or GPIO
// - Timer select picks timer or GPIO
// - East port: five pins with latches
// - System clock out on east pin two
// - Reset clears east directions and clock enable
// - East read: latch or pin by direction
`timescale 1ns/10ps
module pio_top (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [6:0]  west_pin_in,
   output logic      [6:0]  west_pin_out,
   output logic      [6:0]  west_pin_oe,
   input  wire logic [7:0]  middle_pin_in,
   output logic      [7:0]  middle_pin_out,
   output logic      [7:0]  middle_pin_oe,
   output logic      [7:0]  analog_inputs,
   input  wire logic [1:0]  timer_out,
   input  wire logic [1:0]  timer_out_en,
   output logic      [1:0]  second_timer_channel_pins,
   input  wire logic [4:0]  east_pin_in,
   output logic      [4:0]  east_pin_out,
   output logic      [4:0]  east_pin_oe,
   input  wire logic        sysclk_in
);
   localparam int WW = pio_pkg::WEST_W;
   localparam int MW = pio_pkg::MIDDLE_W;
   localparam int EW = pio_pkg::EAST_W;

   logic [WW-1:0] west_sync;
   logic [MW-1:0] middle_sync;
   logic [EW-1:0] east_sync;
   logic [WW-1:0] west_latch;
   logic [WW-1:0] west_direction;
   logic [WW-1:0] west_rd;
   logic [MW-1:0] middle_latch;
   logic [MW-1:0] middle_direction;
   logic [MW-1:0] middle_rd;
   logic [EW-1:0] east_latch;
   logic [EW-1:0] east_direction;
   logic [EW-1:0] east_rd;

   logic                           sysclk_out_enable_ff;
   logic                           nxt_sysclk_out_enable;
   logic [pio_pkg::CHSEL_W-1:0]    chsel_ff;
   logic [pio_pkg::CHSEL_W-1:0]    nxt_chsel;
   logic [pio_pkg::TIMER_CH-1:0]   timer_sel_ff;
   logic [pio_pkg::TIMER_CH-1:0]   nxt_timer_sel;
   logic [31:0]                    prdata_ff;
   logic [31:0]                    nxt_prdata;
   logic                           pready_ff;
   logic                           nxt_pready;
   logic                           pslverr_ff;
   logic                           nxt_pslverr;
   logic [WW-1:0]                  west_out_ff;
   logic [WW-1:0]                  west_oe_ff;
   logic [MW-1:0]                  middle_out_ff;
   logic [MW-1:0]                  middle_oe_ff;
   logic [MW-1:0]                  analog_ff;
   logic [1:0]                     tmr_pin_ff;
   logic [EW-1:0]                  east_out_ff;
   logic [EW-1:0]                  east_oe_ff;
   logic [WW-1:0]                  nxt_west_out;
   logic [WW-1:0]                  nxt_west_oe;
   logic [MW-1:0]                  nxt_middle_out;
   logic [MW-1:0]                  nxt_middle_oe;
   logic [MW-1:0]                  nxt_analog;
   logic [1:0]                     nxt_tmr_pin;
   logic [EW-1:0]                  nxt_east_out;
   logic [EW-1:0]                  nxt_east_oe;
   logic [MW-1:0]                  conv_pin;
   logic [MW-1:0]                  middle_read;
   logic [1:0]                     timer_own;

   logic          acc;
   logic          wr;
   logic [3:0]    idx;
   logic          addr_ok;

   function automatic logic [3:0] reg_index(input logic [11:0] a);
      reg_index = a[5:2];
   endfunction

   function automatic logic hit(input logic [3:0] i, input logic [3:0] r);
      hit = (i == r);
   endfunction

   assign acc     = psel && penable && !pready_ff;
   assign wr      = psel && penable && pwrite && pready_ff;
   assign idx     = reg_index(paddr);
   assign addr_ok = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) &&
                    (hit(idx, pio_pkg::IDX_WEST_DATA) || hit(idx, pio_pkg::IDX_MIDDLE_DATA) ||
                     hit(idx, pio_pkg::IDX_EAST_DATA) || hit(idx, pio_pkg::IDX_WEST_DIR) ||
                     hit(idx, pio_pkg::IDX_MIDDLE_DIR) || hit(idx, pio_pkg::IDX_EAST_DIR) ||
                     hit(idx, pio_pkg::IDX_CONV_SEL) || hit(idx, pio_pkg::IDX_TIMER_SEL) ||
                     hit(idx, pio_pkg::IDX_PIN_STATUS));

   pio_sync #(.W(WW)) u_west_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .async_in (west_pin_in),
      .sync_out (west_sync)
   );
   pio_sync #(.W(MW)) u_middle_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .async_in (middle_pin_in),
      .sync_out (middle_sync)
   );
   pio_sync #(.W(EW)) u_east_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .async_in (east_pin_in),
      .sync_out (east_sync)
   );

   pio_port #(.W(WW)) u_west (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .wr_latch (wr && addr_ok && hit(idx, pio_pkg::IDX_WEST_DATA)),
      .wr_dir   (wr && addr_ok && hit(idx, pio_pkg::IDX_WEST_DIR)),
      .wdata    (pwdata[WW-1:0]),
      .pin_sync (west_sync),
      .latch    (west_latch),
      .dir      (west_direction),
      .rd_val   (west_rd)
   );
   pio_port #(.W(MW)) u_middle (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .wr_latch (wr && addr_ok && hit(idx, pio_pkg::IDX_MIDDLE_DATA)),
      .wr_dir   (wr && addr_ok && hit(idx, pio_pkg::IDX_MIDDLE_DIR)),
      .wdata    (pwdata[MW-1:0]),
      .pin_sync (middle_sync),
      .latch    (middle_latch),
      .dir      (middle_direction),
      .rd_val   (middle_rd)
   );
   pio_port #(.W(EW)) u_east (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .wr_latch (wr && addr_ok && hit(idx, pio_pkg::IDX_EAST_DATA)),
      .wr_dir   (wr && addr_ok && hit(idx, pio_pkg::IDX_EAST_DIR)),
      .wdata    (pwdata[EW-1:0]),
      .pin_sync (east_sync),
      .latch    (east_latch),
      .dir      (east_direction),
      .rd_val   (east_rd)
   );

   // channel select decodes one middle pin
   always_comb begin
      conv_pin = '0;
      if (chsel_ff < pio_pkg::CHSEL_W'(MW)) begin
         conv_pin[chsel_ff[2:0]] = 1'b1;
      end
   end

   // timer owns pin only without converter
   assign timer_own = timer_sel_ff & ~conv_pin[pio_pkg::TIMER_BASE +: 2];

   // converter pin reads latch or zero
   assign middle_read = (conv_pin & middle_direction & middle_latch) | (~conv_pin & middle_rd);

   always_comb begin
      nxt_sysclk_out_enable = sysclk_out_enable_ff;
      nxt_chsel             = chsel_ff;
      nxt_timer_sel         = timer_sel_ff;
      nxt_prdata            = prdata_ff;
      nxt_pready            = acc;
      nxt_pslverr           = acc && !addr_ok;
      if (wr && addr_ok) begin
         if (hit(idx, pio_pkg::IDX_EAST_DIR)) begin
            nxt_sysclk_out_enable = pwdata[pio_pkg::SYSCLK_EN_BIT];
         end
         if (hit(idx, pio_pkg::IDX_CONV_SEL)) begin
            nxt_chsel = pwdata[pio_pkg::CHSEL_W-1:0];
         end
         if (hit(idx, pio_pkg::IDX_TIMER_SEL)) begin
            nxt_timer_sel = pwdata[pio_pkg::TIMER_CH-1:0];
         end
      end
      if (acc && !pwrite) begin
         nxt_prdata = '0;
         if (addr_ok) begin
            case (idx)
               pio_pkg::IDX_WEST_DATA:   nxt_prdata[WW-1:0] = west_rd;
               pio_pkg::IDX_MIDDLE_DATA: nxt_prdata[MW-1:0] = middle_read;
               pio_pkg::IDX_EAST_DATA:   nxt_prdata[EW-1:0] = east_rd;
               pio_pkg::IDX_WEST_DIR:    nxt_prdata[WW-1:0] = west_direction;
               pio_pkg::IDX_MIDDLE_DIR:  nxt_prdata[MW-1:0] = middle_direction;
               pio_pkg::IDX_EAST_DIR: begin
                  nxt_prdata[EW-1:0] = east_direction;
                  nxt_prdata[pio_pkg::SYSCLK_EN_BIT] = sysclk_out_enable_ff;
               end
               pio_pkg::IDX_CONV_SEL:    nxt_prdata[pio_pkg::CHSEL_W-1:0] = chsel_ff;
               pio_pkg::IDX_TIMER_SEL:   nxt_prdata[pio_pkg::TIMER_CH-1:0] = timer_own;
               pio_pkg::IDX_PIN_STATUS:  nxt_prdata[MW-1:0] = middle_sync;
               default:                  nxt_prdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sysclk_out_enable_ff <= 1'b0;
         chsel_ff             <= pio_pkg::CHSEL_RST;
         timer_sel_ff         <= pio_pkg::TIMER_RST;
         prdata_ff            <= '0;
         pready_ff            <= 1'b0;
         pslverr_ff           <= 1'b0;
      end else begin
         sysclk_out_enable_ff <= nxt_sysclk_out_enable;
         chsel_ff             <= nxt_chsel;
         timer_sel_ff         <= nxt_timer_sel;
         prdata_ff            <= nxt_prdata;
         pready_ff            <= nxt_pready;
         pslverr_ff           <= nxt_pslverr;
      end
   end

   always_comb begin
      nxt_west_out = west_latch;
      nxt_west_oe  = west_direction;
      nxt_middle_out = middle_latch;
      nxt_middle_oe  = middle_direction & ~conv_pin;
      nxt_analog     = conv_pin;
      nxt_tmr_pin    = '0;
      for (int i = 0; i < 2; i++) begin
         if (timer_own[i]) begin
            nxt_middle_out[pio_pkg::TIMER_BASE + i] = timer_out[i];
            nxt_middle_oe[pio_pkg::TIMER_BASE + i]  = timer_out_en[i];
            nxt_tmr_pin[i]                          = middle_sync[pio_pkg::TIMER_BASE + i];
         end
      end
      nxt_east_out = east_latch;
      nxt_east_oe  = east_direction;
      // system clock on east pin two
      if (sysclk_out_enable_ff) begin
         nxt_east_out[pio_pkg::SYSCLK_PIN] = sysclk_in;
         nxt_east_oe[pio_pkg::SYSCLK_PIN]  = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         west_out_ff   <= '0;
         west_oe_ff    <= '0;
         middle_out_ff <= '0;
         middle_oe_ff  <= '0;
         analog_ff     <= '0;
         tmr_pin_ff    <= '0;
         east_out_ff   <= '0;
         east_oe_ff    <= '0;
      end else begin
         west_out_ff   <= nxt_west_out;
         west_oe_ff    <= nxt_west_oe;
         middle_out_ff <= nxt_middle_out;
         middle_oe_ff  <= nxt_middle_oe;
         analog_ff     <= nxt_analog;
         tmr_pin_ff    <= nxt_tmr_pin;
         east_out_ff   <= nxt_east_out;
         east_oe_ff    <= nxt_east_oe;
      end
   end

   assign prdata                    = prdata_ff;
   assign pready                    = pready_ff;
   assign pslverr                   = pslverr_ff;
   assign west_pin_out              = west_out_ff;
   assign west_pin_oe               = west_oe_ff;
   assign middle_pin_out            = middle_out_ff;
   assign middle_pin_oe             = middle_oe_ff;
   assign analog_inputs             = analog_ff;
   assign second_timer_channel_pins = tmr_pin_ff;
   assign east_pin_out              = east_out_ff;
   assign east_pin_oe               = east_oe_ff;

   latch_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr && addr_ok && idx == pio_pkg::IDX_WEST_DATA) |=> (west_latch == $past(pwdata[WW-1:0])))
      else $error("west latch not written");

   dir_drive_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      ##1 (west_pin_oe == $past(west_direction)))
      else $error("west enable not following direction");

   reset_dir_a: assert property (@(posedge core_clk)
      $rose(rst_b) |-> (west_direction == '0 && middle_direction == '0 && east_direction == '0))
      else $error("direction not cleared by reset");

   conv_float_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      ##1 ((middle_pin_oe & $past(conv_pin)) == '0))
      else $error("converter pin driven");

   sysclk_out_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      sysclk_out_enable_ff |=> east_pin_oe[pio_pkg::SYSCLK_PIN])
      else $error("system clock pin not enabled");

   apb_answer_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (acc && !pwrite && addr_ok && idx == pio_pkg::IDX_WEST_DATA) |=>
      (pready && prdata[WW-1:0] == ($past(west_direction) & $past(west_latch) |
                                    ~$past(west_direction) & $past(west_sync))))
      else $error("west read value wrong");

   sequence mid_read_s;
      acc && !pwrite && addr_ok && idx == pio_pkg::IDX_MIDDLE_DATA;
   endsequence

   middle_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      mid_read_s |=> ((prdata[MW-1:0] & ~$past(conv_pin)) ==
                      (~$past(conv_pin) & (($past(middle_direction) & $past(middle_latch)) |
                                           (~$past(middle_direction) & $past(middle_sync))))))
      else $error("middle read value wrong");

   conv_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      mid_read_s |=> ((prdata[MW-1:0] & $past(conv_pin)) ==
                      ($past(conv_pin) & $past(middle_direction) & $past(middle_latch))))
      else $error("converter pin read value wrong");

   sysclk_reset_a: assert property (@(posedge core_clk)
      $rose(rst_b) |-> (!sysclk_out_enable_ff && east_pin_oe == '0))
      else $error("clock output not cleared by reset");

   timer_drive_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (timer_own != '0) |=> ((middle_pin_oe[pio_pkg::TIMER_BASE +: 2] & $past(timer_own)) ==
                             ($past(timer_out_en) & $past(timer_own))))
      else $error("timer pin enable not passed through");
endmodule

// ==== tb/pio_pins_model.sv ====
`timescale 1ns/10ps
// Board side of the pins: device drive wins, else external driver level
module pio_pins_model (
   input  wire logic [6:0] west_pin_out,
   input  wire logic [6:0] west_pin_oe,
   input  wire logic [6:0] west_ext,
   output logic      [6:0] west_lvl,
   input  wire logic [7:0] middle_pin_out,
   input  wire logic [7:0] middle_pin_oe,
   input  wire logic [7:0] middle_ext,
   output logic      [7:0] middle_lvl,
   input  wire logic [4:0] east_pin_out,
   input  wire logic [4:0] east_pin_oe,
   input  wire logic [4:0] east_ext,
   output logic      [4:0] east_lvl
);
   assign west_lvl   = (west_pin_oe & west_pin_out) | (~west_pin_oe & west_ext);
   assign middle_lvl = (middle_pin_oe & middle_pin_out) | (~middle_pin_oe & middle_ext);
   assign east_lvl   = (east_pin_oe & east_pin_out) | (~east_pin_oe & east_ext);
endmodule

// ==== tb/parallel_io_ports_abc_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module parallel_io_ports_abc_tb_top;
   logic        core_clk = 1'b0;
   logic        rst_b    = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [6:0]  west_out, west_oe, west_ext = 7'h00, west_lvl;
   logic [7:0]  middle_out, middle_oe, middle_ext = 8'h00, middle_lvl, analog_inputs;
   logic [4:0]  east_out, east_oe, east_ext = 5'h00, east_lvl;
   logic [1:0]  timer_out = 2'h0, timer_out_en = 2'h0, second_timer_channel_pins;
   logic        sysclk_in = 1'b0;
   logic [31:0] rd;
   logic        err;
   logic        clk_lvl;
   int          fail_count = 0;
   int          num_checks = 0;

   always #5 core_clk = ~core_clk;
   always begin
      repeat (8) @(posedge core_clk);
      sysclk_in <= ~sysclk_in;
   end

   pio_top pio_top_i (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .west_pin_in(west_lvl), .west_pin_out(west_out), .west_pin_oe(west_oe),
      .middle_pin_in(middle_lvl), .middle_pin_out(middle_out), .middle_pin_oe(middle_oe),
      .analog_inputs(analog_inputs), .timer_out(timer_out), .timer_out_en(timer_out_en),
      .second_timer_channel_pins(second_timer_channel_pins), .east_pin_in(east_lvl),
      .east_pin_out(east_out), .east_pin_oe(east_oe), .sysclk_in(sysclk_in));

   pio_pins_model pio_pins_model_i (.west_pin_out(west_out), .west_pin_oe(west_oe), .west_ext(west_ext),
      .west_lvl(west_lvl), .middle_pin_out(middle_out), .middle_pin_oe(middle_oe), .middle_ext(middle_ext),
      .middle_lvl(middle_lvl), .east_pin_out(east_out), .east_pin_oe(east_oe), .east_ext(east_ext),
      .east_lvl(east_lvl));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic [11:0] addr, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic slverr);
      int n;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         fail_count++;
         $display("[ERR] %0t no bus answer", $time);
         tally_and_finish();
      end
      rdat    = prdata;
      slverr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr_reg(input logic [3:0] idx, input logic [7:0] d);
      logic [31:0] x;
      logic        e;
      apb({6'h00, idx, 2'b00}, 1'b1, {24'h0, d}, x, e);
   endtask

   task automatic rd_reg(input logic [3:0] idx, output logic [31:0] d);
      logic e;
      apb({6'h00, idx, 2'b00}, 1'b0, 32'h0, d, e);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // Data and direction of one port against pins driven from outside
   task automatic port_case(input logic [3:0] p, input logic [7:0] pin, input logic [7:0] lat,
                            input logic [7:0] dr);
      logic [7:0] m;
      logic [7:0] o;
      logic [7:0] e;
      m = (p == 4'h0) ? 8'h7f : (p == 4'h1) ? 8'hff : 8'h1f;
      @(posedge core_clk);
      west_ext   <= pin[6:0];
      middle_ext <= pin;
      east_ext   <= pin[4:0];
      wr_reg(p, lat);
      wr_reg(p + 4'h4, dr);
      settle(4);
      rd_reg(p, rd);
      `CHK(rd, {24'h0, ((lat & dr) | (pin & ~dr)) & m})
      rd_reg(p + 4'h4, rd);
      `CHK(rd, {24'h0, dr & m})
      settle(1);
      o = (p == 4'h0) ? {1'b0, west_out} : (p == 4'h1) ? middle_out : {3'b000, east_out};
      e = (p == 4'h0) ? {1'b0, west_oe} : (p == 4'h1) ? middle_oe : {3'b000, east_oe};
      `CHK(e, dr & m)
      `CHK(o & dr & m, lat & dr & m)
   endtask

   initial begin
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      settle(2);
      `CHK({west_oe, middle_oe, east_oe}, 20'h0)
      for (int i = 4; i < 7; i++) begin
         rd_reg(i[3:0], rd);
         `CHK(rd, 32'h0)
      end
      rd_reg(pio_pkg::IDX_CONV_SEL, rd);
      `CHK(rd, {27'h0, pio_pkg::CHSEL_RST})
      for (int p = 0; p < 3; p++) begin
         port_case(p[3:0], 8'h55, 8'h2a, 8'h00);
         port_case(p[3:0], 8'h55, 8'h2a, 8'h0f);
         port_case(p[3:0], 8'hc3, 8'h96, 8'h1e);
      end
      apb(12'h00c, 1'b0, 32'h0, rd, err);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(12'h001, 1'b1, 32'hff, rd, err);
      `CHK(err, 1'b1)
      // Channel select walks every pin and two values that pick none
      for (int c = 0; c < 10; c++) begin
         wr_reg(pio_pkg::IDX_CONV_SEL, c[7:0]);
         settle(2);
         `CHK(analog_inputs, (c < 8) ? 8'(1 << c) : 8'h00)
      end
      port_case(4'h1, 8'hff, 8'h08, 8'h08);
      wr_reg(pio_pkg::IDX_CONV_SEL, 8'h03);
      settle(4);
      rd_reg(pio_pkg::IDX_MIDDLE_DATA, rd);
      `CHK(rd, 32'hff)
      `CHK(middle_oe[3], 1'b0)
      wr_reg(pio_pkg::IDX_MIDDLE_DIR, 8'h00);
      rd_reg(pio_pkg::IDX_MIDDLE_DATA, rd);
      `CHK(rd, 32'hf7)
      wr_reg(pio_pkg::IDX_CONV_SEL, 8'h1f);
      @(posedge core_clk);
      timer_out_en <= 2'b11;
      timer_out    <= 2'b10;
      wr_reg(pio_pkg::IDX_TIMER_SEL, 8'h03);
      settle(3);
      `CHK({middle_oe[7:6], middle_out[7:6]}, 4'b1110)
      wr_reg(pio_pkg::IDX_CONV_SEL, 8'h06);
      settle(3);
      `CHK({middle_oe[6], analog_inputs}, 9'h040)
      rd_reg(pio_pkg::IDX_TIMER_SEL, rd);
      `CHK(rd, 32'h2)
      @(posedge core_clk);
      timer_out_en <= 2'b00;
      middle_ext   <= 8'hc0;
      settle(4);
      `CHK(second_timer_channel_pins, 2'b10)
      rd_reg(pio_pkg::IDX_PIN_STATUS, rd);
      `CHK(rd, 32'hc0)
      wr_reg(pio_pkg::IDX_EAST_DIR, 8'h80);
      for (int k = 0; k < 2; k++) begin
         clk_lvl = sysclk_in;
         for (int w = 0; w < 20 && sysclk_in === clk_lvl; w++) begin
            @(posedge core_clk);
         end
         settle(2);
         `CHK({east_oe[2], east_out[2]}, {1'b1, ~clk_lvl})
      end
      wr_reg(pio_pkg::IDX_WEST_DATA, 8'h3c);
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      settle(2);
      `CHK({west_oe, middle_oe, east_oe}, 20'h0)
      rd_reg(pio_pkg::IDX_EAST_DIR, rd);
      `CHK(rd, 32'h0)
      wr_reg(pio_pkg::IDX_WEST_DIR, 8'h7f);
      rd_reg(pio_pkg::IDX_WEST_DATA, rd);
      `CHK(rd, 32'h3c)
      tally_and_finish();
   end
endmodule
